// File: act_cfg.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: 32-bit AXI4-Lite data, one aligned word per register.
// Notes: Definitions only.
`ifndef ACT_CFG_SVH
`define ACT_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ACT_OFF_CTRL0   4'h0
`define ACT_OFF_CTRL1   4'h4
`define ACT_OFF_CTRL2   4'h8
`define ACT_OFF_RESH    4'hc
`define ACT_OFF_RESL    5'h10
`define ACT_OFF_STAT    5'h14
// ****************************************************************
// Field positions and masks
// ****************************************************************
`define ACT_CTRL0_MASK  8'h7f
`define ACT_CTRL1_MASK  8'hf3
`define ACT_CTRL2_MASK  8'hf0
`define ACT_RST_CTRL    8'h00
`define ACT_RUN_BIT     1
`define ACT_EN_BIT      0
`define ACT_FMT_BIT     7
// ****************************************************************
// Timing: 11.5 bit periods = 23 half periods
// ****************************************************************
`define ACT_HALF_PERIODS 5'h17
`define ACT_RC_DIV       7'h1f
`define ACT_RESP_OKAY    2'h0
`define ACT_RESP_SLVERR  2'h2

`endif

// File: act_pkg.sv
// Purpose: Types shared by the converter control block.
// Assumes: Nothing beyond the cfg header.
// Notes: Types only.
`default_nettype none
package act_pkg;
	// Sequencer state.
	typedef enum logic [0:0] {
		ACT_IDLE = 1'b0,
		ACT_CONV = 1'b1
	} act_state_t;
endpackage
`default_nettype wire

// File: act_clkdiv.sv
// Purpose: Half-bit-period enable for the conversion engine.
// Assumes: One system clock; RC clock modelled by a fixed divider.
// Notes: Emits a one-cycle pulse each half bit period.
`include "act_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module act_clkdiv (
	// Clock and reset.
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Control.
	input  wire logic       run,
	input  wire logic [2:0] sel,
	// Enable out.
	output logic            half_tick
);
	logic [6:0] cnt_ff;   // Cycle counter within one half period.
	logic [6:0] limit;    // Terminal count for the selected source.

	// Half of Fosc/N is N/2 system cycles; x11 runs from the RC stand-in.
	always_comb begin
		unique case (sel)
			3'h0: limit = 7'h00; // Divide by 2.
			3'h4: limit = 7'h01; // Divide by 4.
			3'h1: limit = 7'h03; // Divide by 8.
			3'h5: limit = 7'h07; // Divide by 16.
			3'h2: limit = 7'h0f; // Divide by 32.
			3'h6: limit = 7'h1f; // Divide by 64.
			3'h3, 3'h7: limit = `ACT_RC_DIV;
		endcase
	end

	// Counter restarts whenever no conversion runs, so every conversion is aligned.
	always_ff @(posedge aclk) begin
		if (!aresetn || !run || cnt_ff >= limit) begin
			cnt_ff <= 7'h00;
		end else begin
			cnt_ff <= cnt_ff + 7'h01;
		end
	end

	assign half_tick = run && (cnt_ff >= limit);
endmodule
`default_nettype wire

// File: act_sar.sv
// Purpose: Abstract ten-bit successive-approximation engine.
// Assumes: The sampled value is presented on a port and held during a conversion.
// Notes: Resolves one bit every two half ticks, MSB first.
`include "act_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module act_sar (
	// Clock and reset.
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Sequencing.
	input  wire logic       start,
	input  wire logic       half_tick,
	input  wire logic [9:0] sample,
	// Result.
	output logic [9:0]      partial,
	output logic            done
);
	logic [4:0] half_ff;  // Half bit periods elapsed.
	logic [9:0] bits_ff;  // Bits decided so far.
	logic [3:0] n_ff;     // Number of bits decided.

	// Abstract engine: decides bit 9-k on each odd half period.
	always_ff @(posedge aclk) begin
		if (!aresetn || start) begin
			half_ff <= 5'h00;
			bits_ff <= 10'h000;
			n_ff    <= 4'h0;
		end else if (half_tick) begin
			half_ff <= half_ff + 5'h01;
			if (half_ff[0] && n_ff < 4'ha) begin
				bits_ff[4'h9 - n_ff] <= sample[4'h9 - n_ff];
				n_ff <= n_ff + 4'h1;
			end
		end
	end

	// Undecided bits copy the last decided bit, as an aborted result needs.
	always_comb begin
		partial = bits_ff;
		for (int i = 0; i < 10; i++) begin
			if (4'(9 - i) >= n_ff && n_ff != 4'h0) begin
				partial[i] = bits_ff[4'ha - n_ff];
			end
		end
	end

	assign done = half_tick && (half_ff == `ACT_HALF_PERIODS - 5'h01);
endmodule
`default_nettype wire

// File: act_ctrl.sv
// Purpose: Converter control, trigger and result registers over AXI4-Lite.
// Assumes: Trigger inputs are synchronous levels; the analog side is abstract.
// Notes: Result registers are software writable; reads of unmapped words give SLVERR.
`include "act_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module act_ctrl (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Trigger sources, index = trigger code.
	input  wire logic [15:0] trig_in,
	// Analog side.
	input  wire logic [9:0]  sample_value,
	output logic [16:0]      channel_onehot,
	output logic [1:0]       pos_reference_select,
	output logic             converter_powered,
	// Events.
	output logic             conv_done_flag,
	output logic             timer_zero_flag_set,
	output logic             timer_one_flag_set
);
	logic [7:0]  ctrl0_ff;      // Channel, run and enable.
	logic [7:0]  ctrl1_ff;      // Format, clock, reference.
	logic [7:0]  ctrl2_ff;      // Trigger select.
	logic [7:0]  res_hi_ff;     // Result high byte.
	logic [7:0]  res_lo_ff;     // Result low byte.
	logic        done_ff;       // Sticky completion flag.
	logic [15:0] trig_prev_ff;  // Registered trigger copy.
	act_pkg::act_state_t state_ff; // Sequencer state.
	logic        aw_hold_ff;    // Write address captured.
	logic        w_hold_ff;     // Write data captured.
	logic [7:0]  awaddr_ff;     // Captured write address.
	logic [7:0]  wdata_ff;      // Captured write byte.
	logic        wstrb_ff;      // Byte lane zero enabled.
	logic        bvalid_ff;     // Write response pending.
	logic [1:0]  bresp_ff;      // Write response code.
	logic        rvalid_ff;     // Read data pending.
	logic [31:0] rdata_ff;      // Read data word.
	logic [1:0]  rresp_ff;      // Read response code.
	logic        do_write;      // Both write halves present.
	logic        half_tick;     // Half bit period enable.
	logic        eng_done;      // Engine finished.
	logic [9:0]  partial;       // Engine bits so far.
	logic [3:0]  trig_code;     // Trigger select field.
	logic        trig_edge;     // Selected rising edge.
	logic        sw_start;      // Software run write.
	logic        sw_abort;      // Software run clear.
	logic        finish;        // Load the result now.
	logic        run;           // Converting.

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Word decode used by the read path; writes compare the full address.
	function automatic logic [2:0] reg_index(input logic [7:0] a);
		reg_index = 3'(a[4:2]);
	endfunction

	// Known word, used for OKAY versus SLVERR.
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[7:5] == 3'h0) && (a[4:2] <= 3'h5) && (a[1:0] == 2'h0);
	endfunction

	// ****************************************************************
	// AXI4-Lite write path
	// ****************************************************************
	assign s_axi_awready = !aw_hold_ff;
	assign s_axi_wready  = !w_hold_ff;
	assign do_write      = aw_hold_ff && w_hold_ff && !bvalid_ff;

	// Address and data may arrive in either order; each is held until both are in.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 8'h00;
			wstrb_ff   <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_hold_ff) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end else if (do_write) begin
				aw_hold_ff <= 1'b0;
			end
			if (s_axi_wvalid && !w_hold_ff) begin
				w_hold_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata[7:0];
				wstrb_ff  <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	// Response raised at the same edge at which the write takes effect.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `ACT_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= mapped(awaddr_ff) ? `ACT_RESP_OKAY : `ACT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// ****************************************************************
	// AXI4-Lite read path
	// ****************************************************************
	assign s_axi_arready = !rvalid_ff;

	// Reads are answered in the cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= `ACT_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= mapped(s_axi_araddr) ? `ACT_RESP_OKAY : `ACT_RESP_SLVERR;
			unique case (reg_index(s_axi_araddr))
				3'h0: rdata_ff <= {24'h0, ctrl0_ff & `ACT_CTRL0_MASK};
				3'h1: rdata_ff <= {24'h0, ctrl1_ff & `ACT_CTRL1_MASK};
				3'h2: rdata_ff <= {24'h0, ctrl2_ff & `ACT_CTRL2_MASK};
				3'h3: rdata_ff <= {24'h0, res_hi_ff};
				3'h4: rdata_ff <= {24'h0, res_lo_ff};
				3'h5: rdata_ff <= {31'h0, done_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// ****************************************************************
	// Start, abort and trigger decode
	// ****************************************************************
	logic wr_ctrl0; // Software write to the first control register.
	assign wr_ctrl0  = do_write && wstrb_ff && awaddr_ff == 8'(`ACT_OFF_CTRL0);
	assign sw_start  = wr_ctrl0 && wdata_ff[`ACT_RUN_BIT] && ctrl0_ff[`ACT_EN_BIT];
	assign sw_abort  = wr_ctrl0 && !wdata_ff[`ACT_RUN_BIT] && run;
	assign trig_code = ctrl2_ff[7:4];
	// Codes 0000, 1011, 1110 and 1111 have no source wired to their inputs.
	assign trig_edge = (trig_code != 4'h0) && (trig_code != 4'hb) && (trig_code < 4'he)
		&& trig_in[trig_code] && !trig_prev_ff[trig_code];
	assign run       = (state_ff == act_pkg::ACT_CONV);
	assign finish    = run && (eng_done || sw_abort);

	// Registered copy of every trigger line for edge detection.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_prev_ff <= 16'h0000;
		end else begin
			trig_prev_ff <= trig_in;
		end
	end

	// Timer wrap triggers also raise the timer's own flag.
	assign timer_zero_flag_set = trig_edge && trig_code == 4'h3;
	assign timer_one_flag_set  = trig_edge && trig_code == 4'h4;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// An edge during a conversion is ignored; disabling the module stops it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= act_pkg::ACT_IDLE;
		end else begin
			unique case (state_ff)
				act_pkg::ACT_IDLE: begin
					if (ctrl0_ff[`ACT_EN_BIT] && (sw_start || trig_edge)) begin
						state_ff <= act_pkg::ACT_CONV;
					end
				end
				act_pkg::ACT_CONV: begin
					if (finish || !ctrl0_ff[`ACT_EN_BIT]) begin
						state_ff <= act_pkg::ACT_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	// The run bit mirrors the sequencer so it reads one exactly while busy.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl0_ff <= `ACT_RST_CTRL;
		end else begin
			if (wr_ctrl0) begin
				ctrl0_ff[6:2] <= wdata_ff[6:2];
				ctrl0_ff[`ACT_EN_BIT] <= wdata_ff[`ACT_EN_BIT];
			end
			ctrl0_ff[`ACT_RUN_BIT] <= (state_ff == act_pkg::ACT_IDLE)
				? (ctrl0_ff[`ACT_EN_BIT] && (sw_start || trig_edge))
				: !(finish || !ctrl0_ff[`ACT_EN_BIT]);
		end
	end

	// Format, clock and reference; trigger select.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl1_ff <= `ACT_RST_CTRL;
			ctrl2_ff <= `ACT_RST_CTRL;
		end else if (do_write && wstrb_ff) begin
			if (awaddr_ff == 8'(`ACT_OFF_CTRL1)) begin
				ctrl1_ff <= wdata_ff & `ACT_CTRL1_MASK;
			end
			if (awaddr_ff == 8'(`ACT_OFF_CTRL2)) begin
				ctrl2_ff <= wdata_ff & `ACT_CTRL2_MASK;
			end
		end
	end

	// ****************************************************************
	// Results and completion flag
	// ****************************************************************
	// Completion wins over a same-cycle software write to the result registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_hi_ff <= 8'h00;
			res_lo_ff <= 8'h00;
		end else if (finish) begin
			if (ctrl1_ff[`ACT_FMT_BIT]) begin
				res_hi_ff <= {6'h00, partial[9:8]};
				res_lo_ff <= partial[7:0];
			end else begin
				res_hi_ff <= partial[9:2];
				res_lo_ff <= {partial[1:0], 6'h00};
			end
		end else if (do_write && wstrb_ff) begin
			if (awaddr_ff == 8'(`ACT_OFF_RESH)) begin
				res_hi_ff <= wdata_ff;
			end
			if (awaddr_ff == 8'(`ACT_OFF_RESL)) begin
				res_lo_ff <= wdata_ff;
			end
		end
	end

	// Set wins over the software clear of a one at bit zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_ff <= 1'b0;
		end else if (finish) begin
			done_ff <= 1'b1;
		end else if (do_write && wstrb_ff && awaddr_ff == 8'(`ACT_OFF_STAT) && wdata_ff[0]) begin
			done_ff <= 1'b0;
		end
	end
	assign conv_done_flag = done_ff;

	// ****************************************************************
	// Analog routing
	// ****************************************************************
	// Pins 0..11 on bits 0..11, internal sources 28..31 on bits 12..15; reserved none.
	always_comb begin
		channel_onehot = 17'h0_0000;
		if (ctrl0_ff[6:2] <= 5'h0b) begin
			channel_onehot[ctrl0_ff[6:2]] = 1'b1;
		end else if (ctrl0_ff[6:2] >= 5'h1c) begin
			channel_onehot[5'(ctrl0_ff[6:2] - 5'h10)] = 1'b1;
		end
	end
	assign pos_reference_select = ctrl1_ff[1:0];
	assign converter_powered    = ctrl0_ff[`ACT_EN_BIT];

	// ****************************************************************
	// Submodules
	// ****************************************************************
	act_clkdiv u_div (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.run       (run),
		.sel       (ctrl1_ff[6:4]),
		.half_tick (half_tick)
	);

	act_sar u_sar (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.start     (!run),
		.half_tick (half_tick),
		.sample    (sample_value),
		.partial   (partial),
		.done      (eng_done)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_run_follows_state: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl0_ff[`ACT_RUN_BIT] == run) else $error("run bit differs from state");
	a_done_clears_run: assert property (@(posedge aclk) disable iff (!aresetn)
		eng_done && run |=> !ctrl0_ff[`ACT_RUN_BIT] && done_ff) else $error("done kept run");
	a_trig_starts: assert property (@(posedge aclk) disable iff (!aresetn)
		trig_edge && !run && ctrl0_ff[0] |=> run) else $error("trigger missed");
	a_off_no_trig: assert property (@(posedge aclk) disable iff (!aresetn)
		trig_code == 4'h0 |-> !trig_edge) else $error("trigger while off");
	a_right_just: assert property (@(posedge aclk) disable iff (!aresetn)
		finish && ctrl1_ff[7] |=> res_hi_ff[7:2] == 6'h00) else $error("high not zeroed");
	a_left_just: assert property (@(posedge aclk) disable iff (!aresetn)
		finish && !ctrl1_ff[7] |=> res_lo_ff[5:0] == 6'h00 && res_hi_ff == $past(partial[9:2]))
		else $error("left format wrong");
	a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl2_ff[3:0] == 4'h0 && ctrl1_ff[3:2] == 2'h0) else $error("unimplemented bit set");
	a_t0_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		timer_zero_flag_set |-> trig_code == 4'h3 && trig_edge) else $error("timer flag wrong");
	a_t1_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		trig_code == 4'h4 && trig_in[4] && !$past(trig_in[4]) |-> timer_one_flag_set)
		else $error("timer one flag missed");
endmodule
`default_nettype wire

// File: act_trig_peer.sv
// Purpose: Trigger peripherals and analog source beside the converter control.
// Assumes: Levels change by non-blocking assignment just after a rising edge.
// Notes: Callers space pulses; this model never checks conversion timing.
`timescale 1ns/1ps
`default_nettype none
module act_trig_peer (
	// Clock.
	input  wire logic        aclk,
	// Trigger levels and the held analog value.
	output logic      [15:0] trig_in,
	output logic      [9:0]  sample_value
);
	// ****************************************************************
	// Idle levels
	// ****************************************************************
	// All trigger lines rest low so that the first pulse is a clean edge.
	initial begin
		trig_in      = 16'h0000;
		sample_value = 10'h000;
	end

	// The value is held for a whole conversion, as the engine expects.
	task automatic set_sample(input logic [9:0] v);
		sample_value <= v;
	endtask

	// One rising edge on line c, held high for n cycles.
	// Nothing here limits the rate, so a caller can put a second pulse inside a running conversion.
	task automatic fire(input logic [3:0] c, input int n);
		trig_in[c] <= 1'b1;
		repeat (n) @(posedge aclk);
		trig_in[c] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: AXI4-Lite master with bready and rready held high throughout.
// Notes: The fastest clock code keeps trigger and abort conversions short; the conversion test steps through all eight codes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        aclk = 1'b0;
	logic        aresetn;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rdat;
	logic [3:0]  wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp, pref;
	logic [15:0] trig_in;
	logic [9:0]  sample_value, s;
	logic [16:0] ch_oh;
	logic        pwr, done_f, t0_set, t1_set;
	int          err_total = 0, samples_checked = 0, cyc = 0, t0n = 0, t1n = 0;
	int          a, b, i, t0;
	int          hp[8] = '{1, 4, 16, 32, 2, 8, 32, 32};

	always #12.5 aclk = ~aclk;

	act_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .trig_in(trig_in), .sample_value(sample_value),
		.channel_onehot(ch_oh), .pos_reference_select(pref),
		.converter_powered(pwr), .conv_done_flag(done_f),
		.timer_zero_flag_set(t0_set), .timer_one_flag_set(t1_set));

	act_trig_peer peer (.aclk(aclk), .trig_in(trig_in), .sample_value(sample_value));

	// Settled values are sampled on the falling edge, away from updates.
	always @(negedge aclk) begin
		cyc <= cyc + 1;
		if (t0_set === 1'b1) t0n <= t0n + 1;
		if (t1_set === 1'b1) t1n <= t1n + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			complete_run();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// Address and data go out together; each drops at its own handshake.
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic ah, wh, bh;
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid;
			rsp = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!bh);
	endtask

	task automatic rd(input logic [7:0] ad);
		logic ah, rh;
		araddr <= ad;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ah = arvalid & arready;
			rh = rvalid;
			rdat = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
		end while (!rh);
	endtask

	// Bounded wait for the sticky completion flag.
	task automatic wait_done();
		a = 0;
		while (done_f !== 1'b1 && a < 2000) begin
			@(negedge aclk);
			a++;
		end
		@(posedge aclk);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, arvalid} = 3'h0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hf};
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 4; i++) begin
			rd(8'((i == 3) ? 20 : 4 * i));
			chk(rdat, 32'h0);
		end
		wr(8'h04, 32'hff);
		rd(8'h04);
		chk(rdat, 32'hf3);
		wr(8'h08, 32'hff);
		rd(8'h08);
		chk(rdat, 32'hf0);
		wr(8'h00, 32'hfd);
		rd(8'h00);
		chk(rdat, 32'h7d);
		chk(32'(pwr), 32'h1);
		wr(8'h0c, 32'h5a);
		chk(32'(rsp), 32'h0);
		wr(8'h18, 32'h1);
		chk(32'(rsp), 32'h2);
		rd(8'h0c);
		chk(rdat, 32'h5a);
		rd(8'h18);
		chk({rdat[29:0], rsp}, 32'h2);
		$display("test registers done");
		for (i = 0; i < 32; i++) begin
			wr(8'h00, 32'(i * 4 + 1));
			chk(32'(ch_oh), (i < 12) ? 32'h1 << i : (i > 27) ? 32'h1000 << (i - 28) : 0);
			wr(8'h04, 32'(i % 4));
			chk(32'(pref), 32'(i % 4));
		end
		$display("test channels done");
		// Each clock code in turn; odd codes also pick right justification.
		for (i = 0; i < 8; i++) begin
			s = 10'(i * 97 + 5);
			peer.set_sample(s);
			wr(8'h04, 32'(i * 16 + (i % 2) * 128));
			wr(8'h14, 32'h1);
			wr(8'h00, 32'h1);
			repeat (8) @(posedge aclk);
			wr(8'h00, 32'h3);
			t0 = cyc;
			rd(8'h00);
			chk(rdat, 32'h3);
			wait_done();
			chk(32'(cyc - t0 >= 23 * hp[i] - 3 && cyc - t0 <= 23 * hp[i] + 1), 1);
			rd(8'h00);
			chk(rdat, 32'h1);
			rd(8'h0c);
			chk(rdat, (i % 2) ? 32'(s[9:8]) : 32'(s[9:2]));
			rd(8'h10);
			chk(rdat, (i % 2) ? 32'(s[7:0]) : 32'({s[1:0], 6'h00}));
		end
		$display("test conversions done");
		wr(8'h04, 32'h80);
		wr(8'h00, 32'h1);
		for (i = 0; i < 16; i++) begin
			wr(8'h08, 32'(i * 16));
			wr(8'h14, 32'h1);
			a = t0n;
			b = t1n;
			peer.fire(4'(i), 30);
			@(posedge aclk);
			chk(32'(done_f), 32'(i != 0 && i != 11 && i < 14));
			chk(32'(t0n - a), 32'(i == 3));
			chk(32'(t1n - b), 32'(i == 4));
			rd(8'h00);
			chk(rdat, 32'h1);
		end
		// A second edge inside a running conversion must not queue another one.
		wr(8'h08, 32'h10);
		wr(8'h14, 32'h1);
		peer.fire(4'h1, 2);
		repeat (2) @(posedge aclk);
		peer.fire(4'h1, 2);
		wait_done();
		wr(8'h14, 32'h1);
		repeat (40) @(posedge aclk);
		chk(32'(done_f), 32'h0);
		$display("test triggers done");
		wr(8'h08, 32'h0);
		// Four bits are decided before the abort lands; bit six then fills below.
		peer.set_sample(10'h255);
		wr(8'h00, 32'h3);
		repeat (6) @(posedge aclk);
		wr(8'h00, 32'h1);
		rd(8'h00);
		chk(rdat, 32'h1);
		rd(8'h0c);
		chk(rdat, 32'h2);
		rd(8'h10);
		chk(rdat, 32'h7f);
		wr(8'h00, 32'h0);
		chk(32'(pwr), 32'h0);
		$display("test abort done");
		complete_run();
	end
endmodule
`default_nettype wire
